// ===== rsq_cfg.svh
/*
  Holds the shared constants of the regulator sequencer: field positions of the
  control/status and operation configuration words, register addresses and delays.
  Assumes it is included by bare name wherever these macros are needed.
*/
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define RSQ_CLK_MHZ 250
`define RSQ_STARTUP_US 5000
`define RSQ_GAP_US 1000
`define RSQ_STARTUP_CYC (`RSQ_STARTUP_US * `RSQ_CLK_MHZ)
`define RSQ_GAP_CYC (`RSQ_GAP_US * `RSQ_CLK_MHZ)
`define RSQ_CNT_W 24

// -----------------------------------------------------------------------------
// control/status word (0x03) and operation configuration word (0x04)
// -----------------------------------------------------------------------------
`define RSQ_CTRL_ADDR 8'h03
`define RSQ_OPCFG_ADDR 8'h04
`define RSQ_CTRL_ON_HI 7
`define RSQ_CTRL_ON_LO 5
`define RSQ_CTRL_START 4
`define RSQ_CTRL_OK_HI 3
`define RSQ_CTRL_OK_LO 1
`define RSQ_CTRL_FORCE 0
`define RSQ_OPCFG_MSK_HI 3
`define RSQ_OPCFG_MSK_LO 1
`define RSQ_OPCFG_HOT 0
`define RSQ_LAST_SLOT 2'h2
`define RSQ_CODE_NONE 2'h3

`endif

// ===== rsq_pkg.sv
/*
  Types of the regulator sequencer: state enumeration and the state records
  of the top module and of the sequencing engine.
  Assumes rsq_cfg.svh supplies the widths.
*/
`include "rsq_cfg.svh"

package rsq_pkg;

  // ---------------------------------------------------------------------------
  // sequencing engine
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSQ_IDLE = 2'b00,
    RSQ_DELAY = 2'b01,
    RSQ_WAIT = 2'b10,
    RSQ_DONE = 2'b11
  } rsq_fsm_type;

  typedef struct packed {
    rsq_fsm_type st;
    logic [1:0] slot;
    logic [`RSQ_CNT_W-1:0] cnt;
    logic [2:0] en;
  } rsq_seq_state_type;

  // ---------------------------------------------------------------------------
  // top module; regulator vectors are [2]=buck1, [1]=buck2, [0]=linear
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic pin_d;
    logic init;
    logic by_pin;
    logic [2:0] on;
    logic forced;
    logic [2:0] mask;
    logic [2:0] fmask;
    logic [5:0] order;
    logic [2:0] unused;
    logic overheat;
    logic [2:0] en;
    logic [2:0] flag;
    logic shut;
  } rsq_top_state_type;

endpackage

// ===== rsq_plant.sv
/*
  Behavioural model of the regulator outputs behind the enables: each output
  reaches its 80 percent level a fixed time after its enable rises.
  Assumes one clock shared with the sequencer; i_fail pulls an output down.
*/
`timescale 1ns/1ns

module rsq_plant #(
  parameter int PG_DLY = 6
) (
  input wire logic i_clk,         // sequencer clock
  input wire logic [2:0] i_reg_en, // regulator enables from the device
  input wire logic [2:0] i_fail,  // forces an output below its level
  output logic [2:0] o_reg_ok     // 80 percent comparators
);
  // ---------------------------------------------------------------------------
  // ramp counters
  // ---------------------------------------------------------------------------
  int cnt [3];

  // soft start is modelled as a plain delay; a failing output drops at once
  // non-blocking so the device never sees a comparator change at its own sampling edge
  always @(posedge i_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (!i_reg_en[k] || i_fail[k]) begin
        cnt[k] <= 0;
      end else if (cnt[k] < PG_DLY) begin
        cnt[k] <= cnt[k] + 1;
      end
    end
  end

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      o_reg_ok[k] = i_reg_en[k] && !i_fail[k] && cnt[k] >= PG_DLY;
    end
  end
endmodule

// ===== rsq_seq.sv
/*
  Sequencing engine: turns regulators on one slot at a time in fuse order,
  skipping unused ones, waiting a fixed gap after each power good but the last slot's.
  Assumes the control logic holds abort while any fault or manual mode lasts.
*/
`timescale 1ns/1ns
`include "rsq_cfg.svh"

module rsq_seq
  import rsq_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = `RSQ_STARTUP_CYC,
  parameter int unsigned GAP_CYC = `RSQ_GAP_CYC
) (
  input wire logic i_clk,   // 250 MHz clock
  input wire logic i_rst_n, // synchronous reset, active low
  input wire logic i_ce,    // clock enable, freezes state when low
  rsq_seq_if.seq bus        // link to the control logic
);

  rsq_seq_state_type q, d;
  logic [1:0] cur;
  logic [3:0] skipv;

  // one-hot of a fuse slot code; code 3 selects nothing
  function automatic logic [2:0] onehot(input logic [1:0] code);
    case (code)
      2'h0: onehot = 3'h1;
      2'h1: onehot = 3'h2;
      2'h2: onehot = 3'h4;
      default: onehot = 3'h0;
    endcase
  endfunction

  // -----------------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------------
  always_comb begin
    d = q;
    cur = bus.order[2*q.slot +: 2];
    skipv = {1'b1, bus.unused};
    case (q.st)
      RSQ_IDLE: begin
        if (bus.start) begin
          d.st = RSQ_DELAY;
          d.cnt = `RSQ_CNT_W'(STARTUP_CYC);
          d.slot = 2'h0;
          d.en = 3'h0;
        end
      end
      RSQ_DELAY: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - `RSQ_CNT_W'(1);
        end else if (skipv[cur]) begin
          if (q.slot == `RSQ_LAST_SLOT) begin
            d.st = RSQ_DONE;
          end else begin
            d.slot = q.slot + 2'h1;
          end
        end else begin
          d.en = q.en | onehot(cur);
          d.st = RSQ_WAIT;
        end
      end
      RSQ_WAIT: begin
        // the gap only starts once this regulator reports power good
        if ((bus.ok & onehot(cur)) != 3'h0) begin
          if (q.slot == `RSQ_LAST_SLOT) begin
            d.st = RSQ_DONE;
          end else begin
            d.slot = q.slot + 2'h1;
            d.cnt = `RSQ_CNT_W'(GAP_CYC);
            d.st = RSQ_DELAY;
          end
        end
      end
      RSQ_DONE: begin
        d.st = RSQ_DONE;
      end
      default: begin
        d = '0;
      end
    endcase
    // abort wins over everything and clears the counter
    if (bus.abort) begin
      d.st = RSQ_IDLE;
      d.cnt = '0;
      d.slot = 2'h0;
      d.en = 3'h0;
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign bus.en = q.en;
  assign bus.busy = (q.st == RSQ_DELAY) || (q.st == RSQ_WAIT);
  assign bus.done = (q.st == RSQ_DONE);

  // -----------------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  seq_abort_clear_a: assert property (i_ce && bus.abort |=> q.cnt == '0 && q.en == 3'h0 && q.st == RSQ_IDLE)
    else $error("abort did not clear sequencer");
  seq_first_load_a: assert property (i_ce && q.st == RSQ_IDLE && bus.start && !bus.abort |=> q.st == RSQ_DELAY && q.cnt == `RSQ_CNT_W'(STARTUP_CYC))
    else $error("startup delay not loaded");
  seq_gap_start_a: assert property (i_ce && !bus.abort && q.st == RSQ_WAIT && q.slot != `RSQ_LAST_SLOT && (bus.ok & onehot(cur)) != 3'h0 |=> q.st == RSQ_DELAY && q.cnt == `RSQ_CNT_W'(GAP_CYC))
    else $error("gap not started after power good");
  seq_skip_unused_a: assert property (i_ce && !bus.abort && q.st == RSQ_DELAY && q.cnt == '0 && skipv[cur] |=> q.en == $past(q.en))
    else $error("unused regulator was enabled");
  seq_done_c: cover property (q.st == RSQ_WAIT ##1 q.st == RSQ_DONE);

endmodule

// ===== rsq_seq_if.sv
/*
  Carrier between the sequencer control logic and the sequencing engine.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ns

interface rsq_seq_if;
  logic start;
  logic abort;
  logic [5:0] order;
  logic [2:0] unused;
  logic [2:0] ok;
  logic [2:0] en;
  logic busy;
  logic done;

  modport seq (input start, abort, order, unused, ok, output en, busy, done);
  modport ctl (output start, abort, order, unused, ok, input en, busy, done);
endinterface

// ===== rsq_top.sv
/*
  Sequencer and shutdown logic of a three-regulator power unit: host-driven and
  pin-driven activation, power-good flags, masks, module shutdown output and
  lockout/overheat shutdown.
  Assumes pins and analog comparators are asynchronous, fuses are static, and
  i_rst_n is the power-on reset that only drops below the reset threshold.
*/
`timescale 1ns/1ns
`include "rsq_cfg.svh"

// Summary of operation
// - Trigger pin low: host register writes control activation, no pin-driven sequence.
// - Start-all write runs buck 1, then linear regulator, then buck 2.
// - Slot order comes from fuses; fuse-unused regulators are skipped.
// - With pin low, a regulator on and power good, shutdown output follows the forced bit.
// - Trigger pin high: shutdown output is the power-good condition alone.
// - Pin low: output one only if on, power good and forced bit set.
// - Supply lockout turns every regulator off and flags analog circuits off.
// - Registers hold while above reset level; below it the logic stays reset.
// - Retained registers serve the next activation; host rewrites after true reset.
// - Each active regulator's ok flag mirrors its 80 percent comparator.
// - Mask bits set to one remove buck flags from the shutdown condition.
// - Fuse masks govern pin mode; host masks load from fuses at startup.
// - Lockout or overheat turns regulators off and drives shutdown output low.
// - Linear regulator mask bit one removes its flag from the shutdown condition.
// - Overheat latch holds and inhibits activation until host writes zero.
// - Individual host enables disable sequencing; host owns the timing.
// - Each gap starts only after the preceding regulator reports power good.
module rsq_top
  import rsq_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = `RSQ_STARTUP_CYC,
  parameter int unsigned GAP_CYC = `RSQ_GAP_CYC
) (
  input wire logic i_clk,               // 250 MHz clock
  input wire logic i_rst_n,             // synchronous power-on reset, active low
  input wire logic i_ce,                // clock enable
  input wire logic i_en_pin,            // sequence trigger pin, async
  input wire logic i_supply_low_lockout, // supply below lockout level, async
  input wire logic i_die_hot,           // die overtemperature comparator, async
  input wire logic [2:0] i_reg_ok,      // 80 percent comparators, async
  input wire logic [5:0] i_fuse_order,  // slot codes {slot2, slot1, slot0}
  input wire logic [2:0] i_fuse_unused, // fuse: regulator unused
  input wire logic [2:0] i_fuse_mask,   // fuse: power-good masks
  input wire logic i_ctrl_wr,           // write strobe, control/status word
  input wire logic [7:0] i_ctrl_wdata,  // data for control/status word
  input wire logic i_opcfg_wr,          // write strobe, operation config word
  input wire logic [7:0] i_opcfg_wdata, // data for operation config word
  output logic [2:0] o_reg_en,          // regulator enables
  output logic o_module_shutdown_out,   // module shutdown output
  output logic [7:0] o_ctrl_rd,         // control/status word readback
  output logic [7:0] o_opcfg_rd,        // operation config word readback
  output logic o_analog_off,            // analog circuits off except reset monitor
  output logic o_seq_busy               // sequencer running
);

  rsq_top_state_type q, d;
  rsq_seq_if sq ();

  logic pin;
  logic low;
  logic hot;
  logic [2:0] ok_s;
  logic fault;
  logic pin_rise;
  logic pin_fall;
  logic start_all;
  logic manual;
  logic [2:0] msk;
  logic pgok;
  logic anyon;

  // -----------------------------------------------------------------------------
  // sequencing engine
  // -----------------------------------------------------------------------------
  rsq_seq #(
    .STARTUP_CYC(STARTUP_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_seq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .bus(sq)
  );

  // synchronised views; only the second stage is ever read
  assign pin = q.s2[5];
  assign low = q.s2[4];
  assign hot = q.s2[3];
  assign ok_s = q.s2[2:0];

  // fault and mode terms
  assign fault = low | hot | q.overheat;
  assign pin_rise = pin & ~q.pin_d;
  assign pin_fall = ~pin & q.pin_d;
  assign start_all = i_ctrl_wr & i_ctrl_wdata[`RSQ_CTRL_START] & ~pin & q.init;
  assign manual = ~pin & (q.on != 3'h0);
  // pin mode runs on the fuse masks, host mode on the host copies
  assign msk = pin ? q.fmask : q.mask;
  assign pgok = &(q.flag | msk);
  assign anyon = (q.en != 3'h0);

  // engine hookup; fault, manual mode or a pin drop of a pin run abort it
  assign sq.start = (pin_rise | start_all) & ~fault & ~manual & q.init;
  assign sq.abort = fault | manual | (pin_fall & q.by_pin);
  assign sq.order = q.order;
  assign sq.unused = q.unused;
  assign sq.ok = q.flag;

  // -----------------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = {i_en_pin, i_supply_low_lockout, i_die_hot, i_reg_ok};
    d.s2 = q.s1;
    d.pin_d = pin;
    // fuses are caught once after reset release, then kept
    if (!q.init) begin
      d.init = 1'b1;
      d.mask = i_fuse_mask;
      d.fmask = i_fuse_mask;
      d.order = i_fuse_order;
      d.unused = i_fuse_unused;
    end
    if (i_ctrl_wr) begin
      d.on = i_ctrl_wdata[`RSQ_CTRL_ON_HI:`RSQ_CTRL_ON_LO];
      d.forced = i_ctrl_wdata[`RSQ_CTRL_FORCE];
    end
    if (i_opcfg_wr && q.init) begin
      d.mask = i_opcfg_wdata[`RSQ_OPCFG_MSK_HI:`RSQ_OPCFG_MSK_LO];
    end
    // a new overheat event beats a clearing write in the same cycle
    d.overheat = hot | (i_opcfg_wr ? i_opcfg_wdata[`RSQ_OPCFG_HOT] : q.overheat);
    if (pin_rise) begin
      d.by_pin = 1'b1;
    end else if (start_all) begin
      d.by_pin = 1'b0;
    end
    // enables: fault off, then host enables, then the engine
    if (fault) begin
      d.en = 3'h0;
    end else if (manual) begin
      d.en = q.on;
    end else begin
      d.en = sq.en;
    end
    d.flag = ok_s & q.en;
    if (fault) begin
      d.shut = 1'b0;
    end else if (pin) begin
      d.shut = anyon & pgok;
    end else begin
      d.shut = anyon & pgok & q.forced;
    end
  end

  // state register; registers survive anything short of the power-on reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------------
  assign o_reg_en = q.en;
  assign o_module_shutdown_out = q.shut;
  assign o_ctrl_rd = {q.on, 1'b0, q.flag, q.forced};
  assign o_opcfg_rd = {4'h0, q.mask, q.overheat};
  assign o_analog_off = low;
  assign o_seq_busy = sq.busy;

  // -----------------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  shut_fault_low_a: assert property (i_ce && fault |=> !o_module_shutdown_out)
    else $error("shutdown output high during fault");
  en_fault_off_a: assert property (i_ce && fault |=> o_reg_en == 3'h0)
    else $error("regulator on during fault");
  pin_high_follow_a: assert property (i_ce && pin && !fault |=> o_module_shutdown_out == $past(anyon & pgok))
    else $error("pin mode output not power good");
  pin_low_noforce_a: assert property (i_ce && !pin && !q.forced |=> !o_module_shutdown_out)
    else $error("output high without forced bit");
  force_follow_a: assert property (i_ce && !pin && !fault && anyon && pgok |=> o_module_shutdown_out == $past(q.forced))
    else $error("output not following forced bit");
  hot_hold_a: assert property (i_ce && q.overheat && !i_opcfg_wr |=> q.overheat)
    else $error("overheat latch dropped by itself");
  hot_inhibit_a: assert property (i_ce && q.overheat |=> o_reg_en == 3'h0)
    else $error("activation while overheat latched");
  flag_track_a: assert property (i_ce |=> q.flag == $past(ok_s & q.en))
    else $error("ok flag not tracking comparator");
  mask_fuse_a: assert property ($rose(q.init) |-> q.mask == $past(i_fuse_mask) && q.fmask == q.mask)
    else $error("masks not loaded from fuses");
  manual_en_a: assert property (i_ce && manual && !fault |=> o_reg_en == $past(q.on))
    else $error("host enables not applied");
  mask_ignore_a: assert property (i_ce && pin && !fault && anyon && (q.fmask | q.flag) == 3'h7 |=> o_module_shutdown_out)
    else $error("masked flag still blocks output");
  no_pin_start_a: assert property (i_ce && !pin && !start_all && sq.busy == 1'b0 && !sq.done |=> !sq.busy)
    else $error("sequence started without command");

  pin_seq_c: cover property (pin_rise ##[1:1000] sq.busy);
  host_seq_c: cover property (start_all && sq.start ##1 sq.busy);
  manual_c: cover property (manual && !fault ##1 o_reg_en != 3'h0);
  hot_c: cover property (q.overheat ##1 i_opcfg_wr && !i_opcfg_wdata[`RSQ_OPCFG_HOT]);

endmodule

// ===== rsq_top_tb_top.sv
/*
  Self-checking bench of the regulator sequencer: host writes, trigger pin,
  faults and fuse orders, with a plant model closing the power-good loop.
  Assumes short startup and gap counts; fuses change only across a reset.
*/
`timescale 1ns/1ns

module rsq_top_tb_top;
  import rsq_pkg::*;
  localparam int ST = 8;
  localparam int GP = 4;
  localparam int PG = 6;
  typedef struct packed {logic [2:0] k; logic [7:0] v;} rsq_note_type;

  // ---------------------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic pin = 1'b0, low = 1'b0, hot = 1'b0, cwr = 1'b0, owr = 1'b0;
  logic [2:0] ok, fail = 3'h0, fun = 3'h0, fmk = 3'h4;
  logic [5:0] ford = 6'h12;
  logic [7:0] cwd = 8'h00, owd = 8'h00, crd, ord;
  logic [2:0] en;
  logic shut, aoff, gap_ok, busy;
  logic ce = 1'b1;
  int fails = 0, n_checks = 0;
  rsq_note_type q[$];
  event ev_chk;

  always #2 i_clk = ~i_clk;

  rsq_top #(.STARTUP_CYC(ST), .GAP_CYC(GP)) u_rsq_top (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_en_pin(pin),
    .i_supply_low_lockout(low), .i_die_hot(hot), .i_reg_ok(ok),
    .i_fuse_order(ford), .i_fuse_unused(fun), .i_fuse_mask(fmk),
    .i_ctrl_wr(cwr), .i_ctrl_wdata(cwd), .i_opcfg_wr(owr), .i_opcfg_wdata(owd),
    .o_reg_en(en), .o_module_shutdown_out(shut), .o_ctrl_rd(crd),
    .o_opcfg_rd(ord), .o_analog_off(aoff), .o_seq_busy(busy));

  rsq_plant #(.PG_DLY(PG)) u_rsq_plant (
    .i_clk(i_clk), .i_reg_en(en), .i_fail(fail), .o_reg_ok(ok));

  // ---------------------------------------------------------------------------
  // notes, monitor and verdict
  // ---------------------------------------------------------------------------
  // single-bit results: shutdown out, analog off, engine busy, gap timing
  function automatic logic got(input logic [2:0] k);
    case (k)
      3'h1: got = shut;
      3'h4: got = aoff;
      3'h6: got = busy;
      default: got = gap_ok;
    endcase
  endfunction

  task automatic compare(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one compare task per kind of result; all share the mismatch report
  task automatic compare_en(input logic [7:0] e);
    compare({5'h00, en}, e);
  endtask

  task automatic compare_word(input logic [2:0] k, input logic [7:0] e);
    compare((k == 3'h2) ? crd : ord, e);
  endtask

  task automatic compare_bit(input logic [2:0] k, input logic [7:0] e);
    compare({7'h00, got(k)}, e);
  endtask

  task automatic note(input logic [2:0] k, input logic [7:0] v);
    q.push_back({k, v});
    -> ev_chk;
  endtask

  // the monitor drains every queued note, oldest first, whenever the driver flags a result
  initial begin
    rsq_note_type n;
    forever begin
      @(ev_chk);
      while (q.size() > 0) begin
        n = q.pop_front();
        case (n.k)
          3'h0: compare_en(n.v);
          3'h2, 3'h3: compare_word(n.k, n.v);
          default: compare_bit(n.k, n.v);
        endcase
      end
    end
  end

  task automatic conclude;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // runs take under a thousand cycles; a hang is cut well beyond that
  initial begin
    repeat (30000) @(posedge i_clk);
    fails++;
    conclude();
  end

  // ---------------------------------------------------------------------------
  // drivers, all on the falling edge
  // ---------------------------------------------------------------------------
  task automatic wr_ctrl(input logic [7:0] v);
    @(negedge i_clk);
    cwd = v;
    cwr = 1'b1;
    @(negedge i_clk);
    cwr = 1'b0;
  endtask

  task automatic wr_opcfg(input logic [7:0] v);
    @(negedge i_clk);
    owd = v;
    owr = 1'b1;
    @(negedge i_clk);
    owr = 1'b0;
  endtask

  // inputs pass two synchronisers and a flag stage; 14 cycles covers a ramp too
  task automatic expect_val(input logic [2:0] k, input logic [7:0] v);
    repeat (14) @(negedge i_clk);
    note(k, v);
  endtask

  // waits for the next enable change, then notes the expected enables and whether it took at least min cycles
  task automatic wait_en(input logic [2:0] v, input int min);
    logic [2:0] last;
    int c;
    last = en;
    c = 0;
    while (en === last && c < 400) begin
      @(negedge i_clk);
      c++;
    end
    gap_ok = (c >= min);
    note(3'h0, {5'h00, v});
    note(3'h5, 8'h01);
  endtask

  task automatic do_reset;
    i_rst_n = 1'b0;
    repeat (20) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    note(3'h2, 8'h00);
    note(3'h3, {4'h0, fmk, 1'b0});
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    int perm [3];
    int u, j, t;
    logic [2:0] acc;
    void'($urandom(91536));
    do_reset();
    // host start-all runs buck 1, linear, buck 2, the last two after power good
    wr_ctrl(8'h10);
    note(3'h6, 8'h01);
    wait_en(3'h4, ST);
    wait_en(3'h5, PG + GP);
    wait_en(3'h7, PG + GP);
    expect_val(3'h2, 8'h0E);
    note(3'h1, 8'h00);
    note(3'h6, 8'h00);
    wr_ctrl(8'h01);
    expect_val(3'h1, 8'h01);
    // each flag gates the output unless its host mask is set
    for (int i = 0; i < 3; i++) begin
      fail = 3'(1 << i);
      expect_val(3'h1, 8'h00);
      wr_opcfg(8'(2 << i));
      expect_val(3'h1, 8'h01);
      fail = 3'h0;
      wr_opcfg(8'h00);
      expect_val(3'h1, 8'h01);
    end
    // individual enables take over from the engine
    wr_ctrl(8'hA1);
    expect_val(3'h0, 8'h05);
    note(3'h1, 8'h00);
    wr_opcfg(8'h04);
    expect_val(3'h1, 8'h01);
    // a low clock enable drops the write and freezes every register
    ce = 1'b0;
    wr_ctrl(8'h01);
    expect_val(3'h2, 8'hAB);
    note(3'h1, 8'h01);
    ce = 1'b1;
    wr_ctrl(8'h01);
    expect_val(3'h0, 8'h00);
    note(3'h1, 8'h00);
    // overheat latches and inhibits until the host clears it
    wr_ctrl(8'hE1);
    wr_opcfg(8'h00);
    expect_val(3'h1, 8'h01);
    hot = 1'b1;
    expect_val(3'h0, 8'h00);
    note(3'h1, 8'h00);
    note(3'h3, 8'h01);
    hot = 1'b0;
    expect_val(3'h0, 8'h00);
    wr_opcfg(8'h06);
    expect_val(3'h0, 8'h07);
    // supply lockout drops everything yet keeps the registers
    low = 1'b1;
    expect_val(3'h0, 8'h00);
    note(3'h1, 8'h00);
    note(3'h4, 8'h01);
    low = 1'b0;
    expect_val(3'h4, 8'h00);
    note(3'h3, 8'h06);
    wr_ctrl(8'h00);
    expect_val(3'h0, 8'h00);
    // trigger pin runs the fuse sequence; fuse masks rule the output
    pin = 1'b1;
    wait_en(3'h4, ST);
    wait_en(3'h5, PG + GP);
    wait_en(3'h7, PG + GP);
    expect_val(3'h1, 8'h01);
    fail = 3'h1;
    expect_val(3'h1, 8'h00);
    fail = 3'h4;
    expect_val(3'h1, 8'h01);
    fail = 3'h0;
    pin = 1'b0;
    expect_val(3'h0, 8'h00);
    note(3'h6, 8'h00);
    // random fuse orders with one unused regulator, across fresh resets
    for (int r = 0; r < 4; r++) begin
      perm = '{0, 1, 2};
      for (int i = 2; i > 0; i--) begin
        j = $urandom % (i + 1);
        t = perm[i];
        perm[i] = perm[j];
        perm[j] = t;
      end
      u = $urandom % 3;
      fmk = 3'($urandom);
      ford = {2'(perm[2]), 2'(perm[1]), 2'(perm[0])};
      fun = 3'(1 << u);
      do_reset();
      wr_ctrl(8'h10);
      acc = 3'h0;
      for (int s = 0; s < 3; s++) begin
        if (perm[s] != u) begin
          wait_en(acc | 3'(1 << perm[s]), acc == 3'h0 ? ST : PG + GP);
          acc = acc | 3'(1 << perm[s]);
        end
      end
      expect_val(3'h0, {5'h00, acc});
    end
    conclude();
  end
endmodule
